// [ecrc_pkg.sv]
package ecrc_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_HARDWARE_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_POWER_MGMT_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_EEPROM_COMMAND = 8'h08;
	localparam logic [7:0] ADDR_PHY_BCR = 8'h0c;
	localparam logic [7:0] ADDR_PHY_BSR = 8'h10;
	localparam logic [7:0] ADDR_WAKE = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// Field positions
	localparam int SOFT_RESET_BIT = 0;
	localparam int READY_BIT = 0;
	localparam int PMT_SLEEP_BIT = 1;
	localparam int PHY_RST_BIT = 10;
	localparam int E2P_BUSY_BIT = 31;
	localparam int BCR_RESET_BIT = 15;
	localparam int BSR_LINK_BIT = 2;
	// Timing in own units
	localparam int CLK_MHZ = 250;
	localparam int POR_MS = 22;
	localparam int SOFT_RESET_US = 2;
	localparam int PHYRST_US = 100;
	localparam int WAKE_US = 1000;
	localparam int PHY_REG_RST_US = 10;
	localparam int EEPROM_PROBE_CYC = 64;
	localparam int SOFT_RESET_CYC = SOFT_RESET_US * CLK_MHZ;
	localparam int PHYRST_CYC = PHYRST_US * CLK_MHZ;
	localparam int PHY_REG_RST_CYC = PHY_REG_RST_US * CLK_MHZ;
	localparam int POR_CYC = POR_MS * 1000 * CLK_MHZ;
	localparam int WAKE_CYC = WAKE_US * CLK_MHZ;

	typedef struct packed {
		logic pll;
		logic host_bus_interface;
		logic immune;
		logic mac_interface_layer;
		logic mac;
		logic phy;
	} ecrc_rst_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ecrc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ecrc_apb_rsp_t;
endpackage

// [ecrc_sync.sv]
`timescale 1ns/1ps
module ecrc_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic din,
	output logic dout
);
	logic meta;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// [ecrc_timer.sv]
`timescale 1ns/1ps
module ecrc_timer #(
	parameter int W = 24
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic [W-1:0] cycles,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= '0;
			busy <= 1'b0;
		end else if (start) begin
			cnt <= cycles;
			busy <= 1'b1;
		end else if (busy) begin
			cnt <= cnt - 1'b1;
			busy <= (cnt != {{(W-1){1'b0}}, 1'b1});
		end
	end

	assign done = busy && (cnt == {{(W-1){1'b0}}, 1'b1}) && !start;
endmodule

// [ecrc_top.sv]
`timescale 1ns/1ps
module ecrc_top
	import ecrc_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYC,
	parameter int PHYRST_CYCLES = PHYRST_CYC,
	parameter int WAKE_CYCLES = WAKE_CYC,
	parameter int TW = 24
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic hw_reset_n_pin,
	input wire logic [3:0] strap_pins,
	input wire logic phy_link_up,
	// APB slave
	input wire ecrc_pkg::ecrc_apb_req_t apb_req,
	output ecrc_pkg::ecrc_apb_rsp_t apb_rsp,
	// Block resets, active low
	output logic pll_rst_n,
	output logic host_bus_interface_rst_n,
	output logic immune_rst_n,
	output logic mac_interface_layer_rst_n,
	output logic mac_rst_n,
	output logic phy_rst_n,
	// Status
	output logic [3:0] strap_latched,
	output logic eeprom_reload
);
	import ecrc_pkg::*;

	// ==========================================
	// Input synchronisers
	logic pin_n_s;
	logic link_s;

	ecrc_sync u_sync_pin (
		.clk(clk),
		.rst_n(rst_n),
		.din(hw_reset_n_pin),
		.dout(pin_n_s)
	);

	ecrc_sync u_sync_link (
		.clk(clk),
		.rst_n(rst_n),
		.din(phy_link_up),
		.dout(link_s)
	);

	// ==========================================
	// Power-on and pin reset sequencing
	logic [TW-1:0] por_cnt;
	logic [TW-1:0] por_len;
	logic por_active;
	logic pin_active;
	logic full_rst;
	logic full_rst_q;
	logic ready;
	logic sleeping;
	logic [TW-1:0] wake_cnt;

	assign pin_active = !pin_n_s;
	assign full_rst = por_active || pin_active;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			por_cnt <= TW'(POR_CYCLES);
			por_len <= '0;
			por_active <= 1'b1;
		end else if (por_active) begin
			por_cnt <= por_cnt - 1'b1;
			por_len <= por_len + 1'b1;
			por_active <= (por_cnt != {{(TW-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			full_rst_q <= 1'b1;
		end else begin
			full_rst_q <= full_rst;
		end
	end

	// Straps followed while a full reset is active, held from its release
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strap_latched <= 4'h0;
		end else if (full_rst) begin
			strap_latched <= strap_pins;
		end
	end

	// ==========================================
	// APB decode
	logic wr_en;
	logic rd_en;
	logic access;
	logic acc_q;
	logic pready_w;
	logic hit_hw;
	logic hit_pmt;
	logic hit_e2p;
	logic hit_bcr;
	logic hit_bsr;
	logic hit_wake;
	logic hit_stat;
	logic mapped;

	// One wait state: read data captured in the first access cycle
	assign access = apb_req.psel && apb_req.penable;
	assign pready_w = access && acc_q;
	assign wr_en = pready_w && apb_req.pwrite;
	assign rd_en = access && !acc_q && !apb_req.pwrite;
	assign hit_hw = apb_req.paddr == ADDR_HARDWARE_CONFIG;
	assign hit_pmt = apb_req.paddr == ADDR_POWER_MGMT_CONTROL;
	assign hit_e2p = apb_req.paddr == ADDR_EEPROM_COMMAND;
	assign hit_bcr = apb_req.paddr == ADDR_PHY_BCR;
	assign hit_bsr = apb_req.paddr == ADDR_PHY_BSR;
	assign hit_wake = apb_req.paddr == ADDR_WAKE;
	assign hit_stat = apb_req.paddr == ADDR_STATUS;
	assign mapped = hit_hw | hit_pmt | hit_e2p | hit_bcr | hit_bsr | hit_wake | hit_stat;

	// ==========================================
	// Soft reset, PHY reset and EEPROM reload timers
	logic soft_reset_start;
	logic soft_reset_busy;
	logic phyrst_start;
	logic phyrst_busy;
	logic bcr_start;
	logic bcr_busy;
	logic eep_start;
	logic eep_busy;
	logic full_release;

	assign full_release = full_rst_q && !full_rst;
	assign soft_reset_start = wr_en && hit_hw && apb_req.pwdata[SOFT_RESET_BIT] && ready && !soft_reset_busy;
	assign phyrst_start = wr_en && hit_pmt && apb_req.pwdata[PHY_RST_BIT] && ready && !phyrst_busy;
	assign bcr_start = wr_en && hit_bcr && apb_req.pwdata[BCR_RESET_BIT] && ready && !bcr_busy;
	assign eep_start = full_release || soft_reset_start;

	ecrc_timer #(.W(TW)) u_soft_reset (
		.clk(clk),
		.rst_n(rst_n && !full_rst),
		.start(soft_reset_start),
		.cycles(TW'(SOFT_RESET_CYC)),
		.busy(soft_reset_busy),
		.done()
	);

	ecrc_timer #(.W(TW)) u_phyrst (
		.clk(clk),
		.rst_n(rst_n && !full_rst),
		.start(phyrst_start),
		.cycles(TW'(PHYRST_CYCLES)),
		.busy(phyrst_busy),
		.done()
	);

	ecrc_timer #(.W(TW)) u_bcr (
		.clk(clk),
		.rst_n(rst_n && !full_rst),
		.start(bcr_start),
		.cycles(TW'(PHY_REG_RST_CYC)),
		.busy(bcr_busy),
		.done()
	);

	ecrc_timer #(.W(TW)) u_eep (
		.clk(clk),
		.rst_n(rst_n),
		.start(eep_start),
		.cycles(TW'(EEPROM_PROBE_CYC)),
		.busy(eep_busy),
		.done()
	);

	assign eeprom_reload = eep_start;

	// ==========================================
	// Ready flag and sleep/wake
	logic wake_wr;
	logic sleep_wr;

	assign wake_wr = wr_en && hit_wake && sleeping;
	assign sleep_wr = wr_en && hit_pmt && apb_req.pwdata[PMT_SLEEP_BIT] && ready;

	always_ff @(posedge clk) begin
		if (!rst_n || full_rst) begin
			ready <= 1'b0;
			sleeping <= 1'b0;
			wake_cnt <= '0;
		end else if (sleep_wr) begin
			ready <= 1'b0;
			sleeping <= 1'b1;
		end else if (wake_wr) begin
			wake_cnt <= TW'(WAKE_CYCLES);
			sleeping <= 1'b0;
		end else if (wake_cnt != '0) begin
			wake_cnt <= wake_cnt - 1'b1;
			ready <= (wake_cnt == {{(TW-1){1'b0}}, 1'b1});
		end else if (!sleeping) begin
			ready <= 1'b1;
		end
	end

	// ==========================================
	// Reset outputs: asserted at once, released on clock
	ecrc_rst_t rq;
	ecrc_rst_t next_rq;

	always_comb begin
		next_rq.pll = full_rst;
		next_rq.host_bus_interface = full_rst || soft_reset_busy;
		next_rq.immune = full_rst;
		next_rq.mac_interface_layer = full_rst || soft_reset_busy;
		next_rq.mac = full_rst || soft_reset_busy;
		next_rq.phy = full_rst || phyrst_busy || bcr_busy;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rq <= '1;
		end else begin
			rq <= next_rq;
		end
	end

	assign pll_rst_n = !(rq.pll || next_rq.pll);
	assign host_bus_interface_rst_n = !(rq.host_bus_interface || next_rq.host_bus_interface);
	assign immune_rst_n = !(rq.immune || next_rq.immune);
	assign mac_interface_layer_rst_n = !(rq.mac_interface_layer || next_rq.mac_interface_layer);
	assign mac_rst_n = !(rq.mac || next_rq.mac);
	assign phy_rst_n = !(rq.phy || next_rq.phy);

	// ==========================================
	// Read data
	logic [31:0] rd_mux;
	logic [31:0] prdata_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_hw) rd_mux[SOFT_RESET_BIT] = soft_reset_busy;
		if (hit_pmt) begin
			rd_mux[READY_BIT] = ready;
			rd_mux[PMT_SLEEP_BIT] = sleeping;
			rd_mux[PHY_RST_BIT] = phyrst_busy;
		end
		if (hit_e2p) rd_mux[E2P_BUSY_BIT] = eep_busy;
		if (hit_bcr) rd_mux[BCR_RESET_BIT] = bcr_busy;
		if (hit_bsr) rd_mux[BSR_LINK_BIT] = link_s && phy_rst_n;
		if (hit_stat) rd_mux[3:0] = strap_latched;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
			acc_q <= 1'b0;
		end else begin
			acc_q <= access && !acc_q;
			if (rd_en) begin
				prdata_q <= rd_mux;
			end
		end
	end

	assign apb_rsp = '{pready: pready_w, pslverr: pready_w && !mapped, prdata: prdata_q};

	// ==========================================
	// Checks
	AST_PHY_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		(phyrst_busy && !full_rst && !soft_reset_busy) |-> (pll_rst_n && mac_rst_n && host_bus_interface_rst_n))
		else $error("PHY reset spread to other blocks");
	AST_SOFT_SCOPE: assert property (@(posedge clk) disable iff (!rst_n)
		(soft_reset_busy && !full_rst) |-> (!mac_rst_n && !mac_interface_layer_rst_n && pll_rst_n
			&& immune_rst_n && (phy_rst_n || phyrst_busy || bcr_busy)))
		else $error("Soft reset scope wrong");
	AST_FULL_ALL: assert property (@(posedge clk) disable iff (!rst_n)
		full_rst |-> (!pll_rst_n && !phy_rst_n && !immune_rst_n && !host_bus_interface_rst_n
			&& !mac_interface_layer_rst_n && !mac_rst_n))
		else $error("Full reset missed a block");
	AST_NOT_READY: assert property (@(posedge clk) disable iff (!rst_n)
		full_rst |=> !ready)
		else $error("Ready high during full reset");
	AST_READY_AFTER: assert property (@(posedge clk) disable iff (!rst_n)
		(full_release && !sleeping) |=> ##1 ready)
		else $error("Ready not set after reset");
	AST_EEP_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
		eep_start |=> eep_busy [*8])
		else $error("EEPROM busy not held");
	AST_SOFT_START: assert property (@(posedge clk) disable iff (!rst_n || full_rst)
		soft_reset_start |=> soft_reset_busy && !host_bus_interface_rst_n)
		else $error("Soft reset did not start");
	AST_PIN: assert property (@(posedge clk) disable iff (!rst_n)
		!pin_n_s |-> !mac_rst_n)
		else $error("Pin reset ignored");
	AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n || full_rst)
		(wake_wr && !sleep_wr) |=> !ready)
		else $error("Ready set before wake delay");
	AST_PHYRST_START: assert property (@(posedge clk) disable iff (!rst_n || full_rst)
		phyrst_start |=> phyrst_busy && !phy_rst_n)
		else $error("PHY reset did not start");
	AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
		(!mac_rst_n && !full_rst && !soft_reset_busy) |=> (mac_rst_n || full_rst || soft_reset_busy))
		else $error("Reset not released one edge after its cause");
	AST_POR_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(por_active) |-> (por_len == TW'(POR_CYCLES)))
		else $error("Power-on timer length wrong");
	COV_SOFT_RESET: cover property (@(posedge clk) soft_reset_start);
	COV_PHYRST: cover property (@(posedge clk) phyrst_start);
	COV_WAKE: cover property (@(posedge clk) wake_wr);
	COV_PIN: cover property (@(posedge clk) full_release);
endmodule

// [ecrc_host.sv]
`timescale 1ns/1ps
module ecrc_host (
	// Bus
	input wire logic clk,
	input wire ecrc_pkg::ecrc_apb_rsp_t rsp,
	output ecrc_pkg::ecrc_apb_req_t req
);
	import ecrc_pkg::*;
	initial req = '0;
	// ==========
	// One APB transfer, answer taken at the completing edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		while (rsp.pready !== 1'b1) begin
			@(posedge clk);
		end
		e = rsp.pslverr;
		q = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// Released data no longer shows the last value
		req.pwdata <= ~d;
		@(posedge clk);
	endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
	import ecrc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pin_n = 1'b1;
	logic [3:0] straps = 4'h5;
	logic link = 1'b1;
	ecrc_apb_req_t req;
	ecrc_apb_rsp_t rsp;
	logic [5:0] rs;
	logic [3:0] lat;
	logic rl;
	logic [31:0] q;
	logic e;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int rl_n = 0;
	int r0;
	always #2 clk = ~clk;
	ecrc_top #(.POR_CYCLES(50), .PHYRST_CYCLES(20), .WAKE_CYCLES(20)) uut (.clk(clk), .rst_n(rst_n),
		.hw_reset_n_pin(pin_n), .strap_pins(straps), .phy_link_up(link), .apb_req(req), .apb_rsp(rsp),
		.pll_rst_n(rs[5]), .host_bus_interface_rst_n(rs[4]), .immune_rst_n(rs[3]),
		.mac_interface_layer_rst_n(rs[2]), .mac_rst_n(rs[1]), .phy_rst_n(rs[0]), .strap_latched(lat),
		.eeprom_reload(rl));
	ecrc_host host (.clk(clk), .rsp(rsp), .req(req));
	// ==========
	// Helpers
	always @(posedge clk) begin
		cyc++;
		if (rl === 1'b1)
			rl_n++;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0, q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q, e);
	endtask
	task automatic poll(input logic [7:0] a, input int b, input logic v, input int lim);
		int n;
		n = 0;
		rd(a);
		while (q[b] !== v && n < lim) begin
			n++;
			rd(a);
		end
		chk(q[b], v);
	endtask
	// ==========
	// Scenarios
	task automatic t_por();
		repeat (4) @(posedge clk);
		chk(rs, 6'h00);
		rst_n <= 1'b1;
		rd(ADDR_POWER_MGMT_CONTROL);
		chk(q[READY_BIT], 1'b0);
		repeat (20) @(posedge clk);
		rd(ADDR_POWER_MGMT_CONTROL);
		chk(q[READY_BIT], 1'b0);
		poll(ADDR_POWER_MGMT_CONTROL, READY_BIT, 1'b1, 30);
		chk(rs, 6'h3f);
		chk(lat, 4'h5);
		rd(ADDR_STATUS);
		chk(q[3:0], 4'h5);
		rd(ADDR_EEPROM_COMMAND);
		chk(q[E2P_BUSY_BIT], 1'b1);
		poll(ADDR_EEPROM_COMMAND, E2P_BUSY_BIT, 1'b0, 40);
		$display("por done");
	endtask
	task automatic t_soft_reset();
		r0 = rl_n;
		wr(ADDR_HARDWARE_CONFIG, 32'h1);
		chk(rs, 6'h29);
		chk(rl_n - r0, 1);
		rd(ADDR_HARDWARE_CONFIG);
		chk(q[SOFT_RESET_BIT], 1'b1);
		repeat (400) @(posedge clk);
		rd(ADDR_HARDWARE_CONFIG);
		chk(q[SOFT_RESET_BIT], 1'b1);
		poll(ADDR_HARDWARE_CONFIG, SOFT_RESET_BIT, 1'b0, 60);
		poll(ADDR_EEPROM_COMMAND, E2P_BUSY_BIT, 1'b0, 40);
		$display("soft reset done");
	endtask
	task automatic t_phy();
		r0 = rl_n;
		wr(ADDR_POWER_MGMT_CONTROL, 32'h400);
		chk(rs, 6'h3e);
		poll(ADDR_POWER_MGMT_CONTROL, PHY_RST_BIT, 1'b0, 20);
		poll(ADDR_PHY_BSR, BSR_LINK_BIT, 1'b1, 10);
		wr(ADDR_PHY_BCR, 32'h8000);
		chk(rs, 6'h3e);
		rd(ADDR_PHY_BCR);
		chk(q[BCR_RESET_BIT], 1'b1);
		rd(ADDR_PHY_BSR);
		chk(q[BSR_LINK_BIT], 1'b0);
		poll(ADDR_PHY_BCR, BCR_RESET_BIT, 1'b0, 1000);
		chk(rl_n - r0, 0);
		$display("phy reset done");
	endtask
	task automatic t_pin();
		r0 = rl_n;
		straps <= 4'ha;
		pin_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk(rs, 6'h00);
		chk(lat, 4'ha);
		rd(ADDR_POWER_MGMT_CONTROL);
		chk(q[READY_BIT], 1'b0);
		pin_n <= 1'b1;
		poll(ADDR_POWER_MGMT_CONTROL, READY_BIT, 1'b1, 20);
		chk(rl_n - r0, 1);
		straps <= 4'h3;
		repeat (3) @(posedge clk);
		chk(lat, 4'ha);
		$display("pin reset done");
	endtask
	task automatic t_wake();
		wr(ADDR_POWER_MGMT_CONTROL, 32'h2);
		rd(ADDR_POWER_MGMT_CONTROL);
		chk(q[READY_BIT], 1'b0);
		wr(ADDR_WAKE, 32'h0);
		poll(ADDR_POWER_MGMT_CONTROL, READY_BIT, 1'b1, 15);
		rd(8'h1c);
		chk(e, 1'b1);
		$display("wake done");
	endtask
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		t_por();
		t_soft_reset();
		t_phy();
		t_pin();
		t_wake();
		test_done();
	end
endmodule
